//--- rtl/dgp_pkg.sv
package dgp_pkg;

    // register indices, byte address is four times the index
    localparam logic [7:0] DGP_IDX_PA_DATA  = 8'h05;
    localparam logic [7:0] DGP_IDX_PB_DATA  = 8'h06;
    localparam logic [7:0] DGP_IDX_INT_CTL  = 8'h0b;
    localparam logic [7:0] DGP_IDX_OPTION   = 8'h81;
    localparam logic [7:0] DGP_IDX_PA_DIR   = 8'h85;
    localparam logic [7:0] DGP_IDX_PB_DIR   = 8'h86;
    localparam logic [7:0] DGP_IDX_CMP_CTL  = 8'h9c;
    localparam logic [7:0] DGP_IDX_CMP_REF  = 8'h9d;
    localparam logic [7:0] DGP_IDX_CONV_CFG = 8'h9f;
    localparam logic [7:0] DGP_IDX_SPECIAL  = 8'ha0;

    // reset values
    localparam logic [7:0] DGP_RST_OPTION   = 8'hff;
    localparam logic [5:0] DGP_RST_PA_DIR   = 6'h3f;
    localparam logic [7:0] DGP_RST_PB_DIR   = 8'hff;
    localparam logic [5:0] DGP_RST_CMP_CTL  = 6'h07;
    localparam logic [7:0] DGP_RST_CMP_REF  = 8'h00;
    localparam logic [7:0] DGP_RST_CONV_CFG = 8'h00;
    localparam logic       DGP_RST_LVP      = 1'b1;

    // writable bits of the mixed and partly unimplemented registers
    localparam logic [7:0] DGP_MASK_CMP_REF  = 8'hef;
    localparam logic [7:0] DGP_MASK_CONV_CFG = 8'hcf;

    // field positions
    localparam int DGP_OPT_PULLUP_DIS_N = 7;
    localparam int DGP_OPT_EDGE_SEL     = 6;
    localparam int DGP_INT_CHANGE       = 0;
    localparam int DGP_INT_EXT          = 1;
    localparam int DGP_SPC_LVP          = 0;
    localparam int DGP_TIMER_PIN        = 4;
    localparam int DGP_PROG_PIN         = 3;
    localparam int DGP_EXT_IRQ_PIN      = 0;

    // comparator mode field values and analog field pattern
    localparam logic [2:0] DGP_CM_OFF        = 3'h7;
    localparam logic [2:0] DGP_CM_OUT_MODE   = 3'h6;
    localparam logic [2:0] DGP_PCFG_ALL_DIG  = 3'h3;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } dgp_apb_req_t;

    typedef struct packed {
        logic [5:0]  pa_lat;
        logic [7:0]  pb_lat;
        logic [5:0]  pa_dir;
        logic [7:0]  pb_dir;
        logic [7:0]  option;
        logic [5:0]  cmp_ctl;
        logic [7:0]  cmp_ref;
        logic [7:0]  conv_cfg;
        logic        low_voltage_program_mode;
        logic [3:0]  chg_ref;
        logic        chg_flag;
        logic        ext_flag;
        logic        ext_prev;
        logic [31:0] prdata;
    } dgp_state_t;

endpackage

//--- rtl/dgp_pin_cell.sv
`timescale 1ns/10ps
module dgp_pin_cell (
    input  wire logic dir,
    input  wire logic latch,
    input  wire logic alt_en,
    input  wire logic alt_val,
    input  wire logic release_pin,
    input  wire logic open_drain,
    input  wire logic analog,
    input  wire logic pin_in,
    output logic      pin_out,
    output logic      pin_oe_n,
    output logic      pin_rd
);
    logic val;

    // peripheral value replaces the latch; open drain only ever pulls low
    assign val      = alt_en ? alt_val : latch;
    assign pin_out  = open_drain ? 1'b0 : val;
    assign pin_oe_n = dir | release_pin | (open_drain & val);
    // analog pins read as zero so the digital buffer is not trusted
    assign pin_rd   = analog ? 1'b0 : pin_in;
endmodule

//--- rtl/dgp_ports.sv
// The APB interface to the registers was left to the implementer.
`timescale 1ns/10ps
module dgp_ports
    import dgp_pkg::*;
#(
    parameter int APB_AW = 12
) (
    input  wire logic         sys_clk,
    input  wire logic         rst_n,
    input  wire dgp_apb_req_t apb_req,
    output logic [31:0]       prdata,
    output logic              pready,
    output logic              pslverr,
    input  wire logic [5:0]   pa_in,
    output logic [5:0]        pa_out,
    output logic [5:0]        pa_oe_n,
    input  wire logic [7:0]   pb_in,
    output logic [7:0]        pb_out,
    output logic [7:0]        pb_oe_n,
    output logic [7:0]        pb_pullup,
    input  wire logic [1:0]   cmp_result,
    input  wire logic         debug_active,
    output logic              timer_clk,
    output logic              program_mode_pin,
    output logic              change_flag,
    output logic              ext_irq_flag,
    output logic              wake
);
    dgp_state_t s_q;
    dgp_state_t s_d;

    logic [5:0] pa_rd;
    logic [7:0] pb_rd;
    logic [5:0] pa_analog;
    logic [5:0] pa_alt_en;
    logic [7:0] pb_release;
    logic       cmp_out_mode;
    logic       all_digital;
    logic [7:0] idx;
    logic       addr_ok;
    logic       setup;
    logic       access;
    logic [3:0] mismatch;
    logic [7:0] rd_val;
    logic [7:0] wr_mask;
    logic       ext_edge;

    // elaboration check: the decode below is fixed to a twelve bit address
    if (APB_AW != 12) begin : g_bad_aw
        $error("dgp_ports: APB_AW must be 12");
    end

    // register index and decode
    assign idx    = apb_req.paddr[9:2];
    assign setup  = apb_req.psel & ~apb_req.penable;
    assign access = apb_req.psel & apb_req.penable;

    always_comb begin
        addr_ok = 1'b0;
        if (apb_req.paddr[11:10] == 2'h0 && apb_req.paddr[1:0] == 2'h0) begin
            unique case (idx)
                DGP_IDX_PA_DATA, DGP_IDX_PB_DATA, DGP_IDX_INT_CTL, DGP_IDX_OPTION,
                DGP_IDX_PA_DIR, DGP_IDX_PB_DIR, DGP_IDX_CMP_CTL, DGP_IDX_CMP_REF,
                DGP_IDX_CONV_CFG, DGP_IDX_SPECIAL: addr_ok = 1'b1;
                default: addr_ok = 1'b0;
            endcase
        end
    end

    // zero wait states; unmapped words answer with an error
    assign pready  = 1'b1;
    assign pslverr = access & ~addr_ok;
    assign prdata  = s_q.prdata;

    assign all_digital  = (s_q.conv_cfg[3:1] == DGP_PCFG_ALL_DIG);
    assign cmp_out_mode = (s_q.cmp_ctl[2:0] == DGP_CM_OUT_MODE);
    // reset field values leave pins 0 to 3 and 5 analog; pin 4 is never analog
    assign pa_analog[3:0] = {4{~all_digital | (s_q.cmp_ctl[2:0] != DGP_CM_OFF)}};
    assign pa_analog[4]   = 1'b0;
    assign pa_analog[5]   = ~all_digital;
    // comparator outputs take over pins 4 and 5
    assign pa_alt_en = {cmp_out_mode, cmp_out_mode, 4'h0};

    // programming mode and debug take their pins
    assign pb_release = {debug_active, debug_active, 2'h0, s_q.low_voltage_program_mode, 3'h0};

    // one cell per first port pin
    for (genvar i = 0; i < 6; i++) begin : g_pa
        dgp_pin_cell u_cell (
            .dir         (s_q.pa_dir[i]),
            .latch       (s_q.pa_lat[i]),
            .alt_en      (pa_alt_en[i]),
            .alt_val     (cmp_result[i == 5 ? 1 : 0]),
            .release_pin (1'b0),
            // open drain on the timer pin
            .open_drain  (i == DGP_TIMER_PIN),
            .analog      (pa_analog[i]),
            .pin_in      (pa_in[i]),
            .pin_out     (pa_out[i]),
            .pin_oe_n    (pa_oe_n[i]),
            .pin_rd      (pa_rd[i])
        );
    end

    // one cell per second port pin
    for (genvar j = 0; j < 8; j++) begin : g_pb
        dgp_pin_cell u_cell (
            .dir         (s_q.pb_dir[j]),
            .latch       (s_q.pb_lat[j]),
            .alt_en      (1'b0),
            .alt_val     (1'b0),
            .release_pin (pb_release[j]),
            .open_drain  (1'b0),
            .analog      (1'b0),
            .pin_in      (pb_in[j]),
            .pin_out     (pb_out[j]),
            .pin_oe_n    (pb_oe_n[j]),
            .pin_rd      (pb_rd[j])
        );
    end

    // timer always sees its pin, even when it is driven
    assign timer_clk        = pa_in[DGP_TIMER_PIN];
    assign program_mode_pin = s_q.low_voltage_program_mode & pb_in[DGP_PROG_PIN];

    // pull-ups only on inputs, bit is active low
    assign pb_pullup = {8{~s_q.option[DGP_OPT_PULLUP_DIS_N]}} & s_q.pb_dir;

    // outputs masked out of the comparison
    assign mismatch = (pb_rd[7:4] ^ s_q.chg_ref) & s_q.pb_dir[7:4];

    // rising edge when select is set, falling when clear
    assign ext_edge = s_q.option[DGP_OPT_EDGE_SEL]
                      ? (pb_rd[DGP_EXT_IRQ_PIN] & ~s_q.ext_prev)
                      : (~pb_rd[DGP_EXT_IRQ_PIN] & s_q.ext_prev);

    assign change_flag  = s_q.chg_flag;
    assign ext_irq_flag = s_q.ext_flag;
    // a live mismatch or pending flag asks for wake-up
    assign wake         = s_q.chg_flag | (|mismatch);

    // write mask: zero upper byte means the whole port is addressed
    assign wr_mask = (apb_req.pwdata[15:8] == 8'h00) ? 8'hff : apb_req.pwdata[15:8];

    // read mux, data words return pin levels
    always_comb begin
        rd_val = 8'h00;
        unique case (idx)
            // upper bits of the first port read zero
            DGP_IDX_PA_DATA:  rd_val = {2'h0, pa_rd};
            DGP_IDX_PB_DATA:  rd_val = pb_rd;
            DGP_IDX_INT_CTL:  rd_val = {6'h00, s_q.ext_flag, s_q.chg_flag};
            DGP_IDX_OPTION:   rd_val = s_q.option;
            DGP_IDX_PA_DIR:   rd_val = {2'h0, s_q.pa_dir};
            DGP_IDX_PB_DIR:   rd_val = s_q.pb_dir;
            DGP_IDX_CMP_CTL:  rd_val = {cmp_result[1], cmp_result[0], s_q.cmp_ctl};
            DGP_IDX_CMP_REF:  rd_val = s_q.cmp_ref;
            DGP_IDX_CONV_CFG: rd_val = s_q.conv_cfg;
            DGP_IDX_SPECIAL:  rd_val = {7'h00, s_q.low_voltage_program_mode};
            default:          rd_val = 8'h00;
        endcase
    end

    // next state
    always_comb begin
        s_d = s_q;
        // read data is captured in setup so it comes from a flop
        if (setup) begin
            s_d.prdata = addr_ok ? {24'h000000, rd_val} : 32'h00000000;
        end
        if (access && addr_ok && apb_req.pwrite) begin
            unique case (idx)
                // unaddressed bits take the sampled pin levels
                DGP_IDX_PA_DATA:  s_d.pa_lat = (pa_rd & ~wr_mask[5:0]) | (apb_req.pwdata[5:0] & wr_mask[5:0]);
                DGP_IDX_PB_DATA:  s_d.pb_lat = (pb_rd & ~wr_mask) | (apb_req.pwdata[7:0] & wr_mask);
                DGP_IDX_INT_CTL: begin
                    s_d.chg_flag = apb_req.pwdata[DGP_INT_CHANGE];
                    s_d.ext_flag = apb_req.pwdata[DGP_INT_EXT];
                end
                DGP_IDX_OPTION:   s_d.option   = apb_req.pwdata[7:0];
                // direction stays writable whatever the pin use
                DGP_IDX_PA_DIR:   s_d.pa_dir   = apb_req.pwdata[5:0];
                DGP_IDX_PB_DIR:   s_d.pb_dir   = apb_req.pwdata[7:0];
                DGP_IDX_CMP_CTL:  s_d.cmp_ctl  = apb_req.pwdata[5:0];
                DGP_IDX_CMP_REF:  s_d.cmp_ref  = apb_req.pwdata[7:0] & DGP_MASK_CMP_REF;
                DGP_IDX_CONV_CFG: s_d.conv_cfg = apb_req.pwdata[7:0] & DGP_MASK_CONV_CFG;
                DGP_IDX_SPECIAL:  s_d.low_voltage_program_mode      = apb_req.pwdata[DGP_SPC_LVP];
                default:          s_d.low_voltage_program_mode      = s_q.low_voltage_program_mode;
            endcase
        end
        // any access of the second port refreshes the reference
        if (access && addr_ok && idx == DGP_IDX_PB_DATA) begin
            s_d.chg_ref = pb_rd[7:4];
        end
        // set wins over a software clear
        if (|mismatch) begin
            s_d.chg_flag = 1'b1;
        end
        // edge interrupt on bit 0, set wins as well
        if (ext_edge) begin
            s_d.ext_flag = 1'b1;
        end
        s_d.ext_prev = pb_rd[DGP_EXT_IRQ_PIN];
    end

    // state register, synchronous reset
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            s_q          <= '0;
            s_q.pa_dir   <= DGP_RST_PA_DIR;
            s_q.pb_dir   <= DGP_RST_PB_DIR;
            s_q.option   <= DGP_RST_OPTION;
            // comparators off, analog field all analog
            s_q.cmp_ctl  <= DGP_RST_CMP_CTL;
            s_q.cmp_ref  <= DGP_RST_CMP_REF;
            s_q.conv_cfg <= DGP_RST_CONV_CFG;
            s_q.low_voltage_program_mode      <= DGP_RST_LVP;
        end else begin
            s_q <= s_d;
        end
    end

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    sequence pb_access_s;
        access && addr_ok && idx == DGP_IDX_PB_DATA;
    endsequence

    sequence rise_s;
        s_q.option[DGP_OPT_EDGE_SEL] && !s_q.ext_prev && pb_rd[DGP_EXT_IRQ_PIN];
    endsequence

    // falling edge while the select bit is clear
    sequence fall_s;
        !s_q.option[DGP_OPT_EDGE_SEL] && s_q.ext_prev && !pb_rd[DGP_EXT_IRQ_PIN];
    endsequence

    AST_DIR_FLOATS: assert property (s_q.pb_dir[1] |-> pb_oe_n[1])
        else $error("input pin is driven");
    AST_TIMER_OPEN_DRAIN: assert property (!pa_oe_n[4] |-> pa_out[4] == 1'b0)
        else $error("timer pin drives high");
    AST_PULLUP_RESET: assert property ($rose(rst_n) |-> pb_pullup == 8'h00)
        else $error("pull-ups on after reset");
    AST_PULLUP_OUTPUT: assert property (!s_q.pb_dir[5] |-> !pb_pullup[5])
        else $error("pull-up on an output pin");
    AST_OUT_EXCLUDED: assert property (s_q.pb_dir[7:4] == 4'h0 |-> mismatch == 4'h0)
        else $error("output pin caused a mismatch");
    AST_CHANGE_SETS: assert property (mismatch != 4'h0 |=> change_flag)
        else $error("mismatch did not set the flag");
    AST_REF_REFRESH: assert property (pb_access_s |=> s_q.chg_ref == $past(pb_rd[7:4]))
        else $error("reference not refreshed");
    AST_FLAG_HOLDS: assert property (mismatch != 4'h0 ##1 mismatch != 4'h0 |-> change_flag ##1 change_flag)
        else $error("flag cleared under mismatch");
    AST_EXT_RISE: assert property (rise_s |=> ext_irq_flag)
        else $error("edge flag missed");
    AST_LVP_PIN: assert property (s_q.low_voltage_program_mode |-> pb_oe_n[3])
        else $error("programming pin driven");
    AST_WAKE: assert property (((pb_in[7:4] ^ s_q.chg_ref) & s_q.pb_dir[7:4]) != 4'h0 |-> wake)
        else $error("no wake with change pending");
    AST_ANALOG_ZERO: assert property ($rose(rst_n) ##1 apb_req.psel |-> pa_rd[3:0] == 4'h0)
        else $error("analog pins read non-zero");

    AST_EXT_FALL: assert property (fall_s |=> ext_irq_flag)
        else $error("falling edge flag missed");

    AST_PA_DIR_FLOATS: assert property (s_q.pa_dir[0] |-> pa_oe_n[0])
        else $error("first port input pin is driven");

    AST_PB_DRIVES: assert property (!s_q.pb_dir[2] |-> !pb_oe_n[2] && pb_out[2] == s_q.pb_lat[2])
        else $error("second port output not driven from latch");

    AST_PA_DRIVES: assert property (!s_q.pa_dir[1] |-> !pa_oe_n[1] && pa_out[1] == s_q.pa_lat[1])
        else $error("first port output not driven from latch");

    AST_PORT_READ: assert property (setup && addr_ok && idx == DGP_IDX_PB_DATA |=> prdata[7:0] == $past(pb_in))
        else $error("port read is not the pin level");

    AST_PB_WRITE: assert property (access && addr_ok && apb_req.pwrite && idx == DGP_IDX_PB_DATA
                                   && apb_req.pwdata[15:8] == 8'h00 |=> s_q.pb_lat == $past(apb_req.pwdata[7:0]))
        else $error("port write did not reach the latch");

    AST_PULLUP_ON: assert property (!s_q.option[DGP_OPT_PULLUP_DIS_N] && s_q.pb_dir[0] |-> pb_pullup[0])
        else $error("pull-up not enabled");

    AST_CHANGE_IDLE: assert property (mismatch == 4'h0 && !change_flag
                                      && !(access && addr_ok && apb_req.pwrite && idx == DGP_IDX_INT_CTL)
                                      |=> !change_flag)
        else $error("change flag set without mismatch");

    AST_DEBUG_RELEASE: assert property (debug_active |-> pb_oe_n[7:6] == 2'b11)
        else $error("debug pins still driven");

    AST_PROG_PIN: assert property (!s_q.low_voltage_program_mode |-> !program_mode_pin)
        else $error("programming pin active with mode off");

    AST_DIR_WRITABLE: assert property (access && addr_ok && apb_req.pwrite && idx == DGP_IDX_PA_DIR
                                       |=> s_q.pa_dir == $past(apb_req.pwdata[5:0]))
        else $error("direction write lost");

    AST_UPPER_ZERO: assert property (setup && addr_ok && idx == DGP_IDX_PA_DIR |=> prdata[7:6] == 2'b00)
        else $error("unimplemented bits read non-zero");

    AST_TIMER_PIN: assert property (timer_clk == pa_in[DGP_TIMER_PIN])
        else $error("timer clock not taken from its pin");

    AST_OUT_BIT: assert property (!s_q.pb_dir[4] |-> !mismatch[0])
        else $error("output bit took part in comparison");

    AST_REF_WRITE: assert property (access && addr_ok && apb_req.pwrite && idx == DGP_IDX_PB_DATA
                                    |=> s_q.chg_ref == $past(pb_rd[7:4]))
        else $error("reference not refreshed on write");
endmodule

//--- verif/dgp_board_model.sv
`timescale 1ns/10ps
// board circuitry on both ports; released lines without pull-up wander
module dgp_board_model (
    input  wire logic       sys_clk,
    input  wire logic [5:0] pa_out,
    input  wire logic [5:0] pa_oe_n,
    input  wire logic [5:0] pa_dv,
    input  wire logic [5:0] pa_de,
    input  wire logic [7:0] pb_out,
    input  wire logic [7:0] pb_oe_n,
    input  wire logic [7:0] pb_pullup,
    input  wire logic [7:0] pb_dv,
    input  wire logic [7:0] pb_de,
    output logic [5:0]      pa_in,
    output logic [7:0]      pb_in
);
    logic [5:0] pa_q = 6'h00;
    logic [7:0] pb_q = 8'h00;

    // last level, so a floating line shows its inverse instead of a guess
    always @(posedge sys_clk) begin
        pa_q <= pa_in;
        pb_q <= pb_in;
    end

    // device driver wins, then board driver, then pull-up, else floating
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            pa_in[i] = !pa_oe_n[i] ? pa_out[i] : (pa_de[i] ? pa_dv[i] : ~pa_q[i]);
        end
        for (int i = 0; i < 8; i++) begin
            pb_in[i] = !pb_oe_n[i] ? pb_out[i] : (pb_de[i] ? pb_dv[i] : (pb_pullup[i] ? 1'b1 : ~pb_q[i]));
        end
    end
endmodule

//--- verif/tb_top.sv
`timescale 1ns/10ps
module tb_top
    import dgp_pkg::*;
;
    logic         sys_clk = 1'b0;
    logic         rst_n = 1'b0;
    dgp_apb_req_t apb = '0;
    logic [31:0]  prdata, rd;
    logic         pready, pslverr, err, timer_clk, program_mode_pin, change_flag, ext_irq_flag, wake;
    logic [5:0]   pa_in, pa_out, pa_oe_n;
    logic [5:0]   pa_dv = 6'h3f;
    logic [7:0]   pb_in, pb_out, pb_oe_n, pb_pullup;
    logic [7:0]   pb_dv = 8'h00;
    logic [1:0]   cmp_result = 2'b00;
    logic         debug_active = 1'b0;
    int           num_errors = 0;
    int           checks = 0;
    int           cycles = 0;

    dgp_ports dut (.sys_clk(sys_clk), .rst_n(rst_n), .apb_req(apb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pa_in(pa_in), .pa_out(pa_out), .pa_oe_n(pa_oe_n), .pb_in(pb_in),
        .pb_out(pb_out), .pb_oe_n(pb_oe_n), .pb_pullup(pb_pullup), .cmp_result(cmp_result),
        .debug_active(debug_active), .timer_clk(timer_clk), .program_mode_pin(program_mode_pin),
        .change_flag(change_flag), .ext_irq_flag(ext_irq_flag), .wake(wake));

    dgp_board_model board (.sys_clk(sys_clk), .pa_out(pa_out), .pa_oe_n(pa_oe_n), .pa_dv(pa_dv),
        .pa_de(6'h3f), .pb_out(pb_out), .pb_oe_n(pb_oe_n), .pb_pullup(pb_pullup), .pb_dv(pb_dv),
        .pb_de(8'hff), .pa_in(pa_in), .pb_in(pb_in));

    // 250 MHz clock
    initial begin
        forever #2 sys_clk = ~sys_clk;
    end

    task automatic finish_test;
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // a run still going at 5000 cycles is ended here and counted as failed
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            finish_test();
        end
    end

    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp);
        chk_val({24'h0, got}, {24'h0, exp});
    endtask

    // one apb transfer; request held until pready is seen high or 20 cycles pass
    task automatic xfer(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge sys_clk);
        apb <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: {2'b00, idx, 2'b00}, pwdata: wd};
        @(posedge sys_clk);
        apb.penable <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        apb <= '0;
        if (n >= 20) num_errors++;
        #1;
    endtask

    task automatic wr_reg(input logic [7:0] idx, input logic [31:0] wd);
        xfer(1'b1, idx, wd);
    endtask

    task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
        xfer(1'b0, idx, 32'h0);
        chk_val(rd, {24'h0, exp});
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    initial begin
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        // reset state of registers and pins
        rd_chk(DGP_IDX_OPTION, 8'hff);
        rd_chk(DGP_IDX_PA_DIR, 8'h3f);
        rd_chk(DGP_IDX_PB_DIR, 8'hff);
        rd_chk(DGP_IDX_CMP_CTL, 8'h07);
        rd_chk(DGP_IDX_CONV_CFG, 8'h00);
        rd_chk(DGP_IDX_PA_DATA, 8'h10);
        chk_pin(pb_pullup, 8'h00);
        chk_pin({2'b00, pa_oe_n}, 8'h3f);
        xfer(1'b0, 8'h40, 32'h0);
        chk_val({rd[30:0], err}, 32'h1);
        chk_pin({7'h0, pready}, 8'h01);
        $display("test reset done");
        // port a: analog selection, open drain bit, unimplemented bits
        // permitted analog pattern
        wr_reg(DGP_IDX_CONV_CFG, 32'h06);
        rd_chk(DGP_IDX_PA_DATA, 8'h3f);
        wr_reg(DGP_IDX_CMP_CTL, 32'h06);
        rd_chk(DGP_IDX_PA_DATA, 8'h30);
        @(posedge sys_clk) cmp_result <= 2'b10;
        rd_chk(DGP_IDX_CMP_CTL, 8'h86);
        wr_reg(DGP_IDX_PA_DIR, 32'h00);
        chk_pin({2'b00, pa_out}, 8'h20);
        wr_reg(DGP_IDX_CMP_CTL, 32'h07);
        wr_reg(DGP_IDX_PA_DIR, 32'h00);
        wr_reg(DGP_IDX_PA_DATA, 32'h2f);
        chk_pin({2'b00, pa_out}, 8'h2f);
        chk_pin({2'b00, pa_oe_n}, 8'h00);
        wr_reg(DGP_IDX_PA_DATA, 32'hff);
        chk_pin({2'b00, pa_oe_n}, 8'h10);
        @(posedge sys_clk) pa_dv <= 6'h00;
        idle(2);
        rd_chk(DGP_IDX_PA_DATA, 8'h2f);
        chk_pin({7'h0, timer_clk}, 8'h00);
        wr_reg(DGP_IDX_PA_DIR, 32'hff);
        rd_chk(DGP_IDX_PA_DIR, 8'h3f);
        wr_reg(DGP_IDX_CMP_REF, 32'hff);
        rd_chk(DGP_IDX_CMP_REF, 8'hef);
        $display("test port_a done");
        // port b: programming pin, outputs, pull-ups, read-modify-write
        @(posedge sys_clk) pb_dv <= 8'h08;
        idle(2);
        chk_pin({7'h0, program_mode_pin}, 8'h01);
        wr_reg(DGP_IDX_SPECIAL, 32'h00);
        chk_pin({7'h0, program_mode_pin}, 8'h00);
        wr_reg(DGP_IDX_PB_DIR, 32'h00);
        wr_reg(DGP_IDX_PB_DATA, 32'h5a);
        chk_pin(pb_oe_n, 8'h00);
        chk_pin(pb_out, 8'h5a);
        rd_chk(DGP_IDX_PB_DATA, 8'h5a);
        @(posedge sys_clk) debug_active <= 1'b1;
        idle(1);
        chk_pin(pb_oe_n, 8'hc0);
        @(posedge sys_clk) debug_active <= 1'b0;
        wr_reg(DGP_IDX_PB_DIR, 32'h0f);
        wr_reg(DGP_IDX_OPTION, 32'h7f);
        chk_pin(pb_pullup, 8'h0f);
        wr_reg(DGP_IDX_PB_DIR, 32'hf0);
        @(posedge sys_clk) pb_dv <= 8'ha0;
        idle(2);
        wr_reg(DGP_IDX_PB_DATA, 32'h0f05);
        wr_reg(DGP_IDX_PB_DIR, 32'h00);
        chk_pin(pb_out, 8'ha5);
        $display("test port_b done");
        // change detection on upper input pins
        // reads only to rearm
        wr_reg(DGP_IDX_PB_DIR, 32'hf0);
        @(posedge sys_clk) pb_dv <= 8'h00;
        idle(2);
        xfer(1'b0, DGP_IDX_PB_DATA, 32'h0);
        wr_reg(DGP_IDX_INT_CTL, 32'h00);
        chk_pin({7'h0, change_flag}, 8'h00);
        @(posedge sys_clk) pb_dv <= 8'h80;
        idle(2);
        chk_pin({6'h0, wake, change_flag}, 8'h03);
        wr_reg(DGP_IDX_INT_CTL, 32'h00);
        chk_pin({7'h0, change_flag}, 8'h01);
        rd_chk(DGP_IDX_PB_DATA, 8'h85);
        wr_reg(DGP_IDX_INT_CTL, 32'h00);
        chk_pin({7'h0, change_flag}, 8'h00);
        @(posedge sys_clk) pb_dv <= 8'h00;
        idle(2);
        xfer(1'b0, DGP_IDX_PB_DATA, 32'h0);
        wr_reg(DGP_IDX_INT_CTL, 32'h00);
        wr_reg(DGP_IDX_PB_DIR, 32'h70);
        idle(2);
        chk_pin({7'h0, change_flag}, 8'h00);
        $display("test change done");
        // external edge interrupt, both edge selections
        wr_reg(DGP_IDX_PB_DIR, 32'hff);
        for (int e = 0; e < 2; e++) begin
            wr_reg(DGP_IDX_OPTION, (e == 1) ? 32'hff : 32'hbf);
            @(posedge sys_clk) pb_dv <= {7'h0, ~e[0]};
            idle(2);
            wr_reg(DGP_IDX_INT_CTL, 32'h00);
            @(posedge sys_clk) pb_dv <= {7'h0, e[0]};
            idle(2);
            chk_pin({7'h0, ext_irq_flag}, 8'h01);
            wr_reg(DGP_IDX_INT_CTL, 32'h00);
            @(posedge sys_clk) pb_dv <= {7'h0, ~e[0]};
            idle(2);
            chk_pin({7'h0, ext_irq_flag}, 8'h00);
        end
        $display("test edge done");
        finish_test();
    end
endmodule
